// [verilog/simd_fraction_arith_unit.sv]
// Notes on behaviour
// - Q15 pair add per half, optional clamp
// - Q31 add always clamps on overflow
// - Byte quad add, optional clamp to 255
// - Q15 pair subtract per half, optional clamp
// - Q31 subtract always clamps on overflow
// - Byte quad subtract, optional floor at zero
// - Add writes sum and records carry bit
// - Add plus held carry, carry untouched
// - Index minus decrement, reload on underflow
// - Sum four bytes, zero-extend to word
// - Q15 pair magnitude, -1.0 gives maximum
// - Q31 magnitude, -1.0 gives maximum
// - Pack four Q15 tops into bytes
// - Shift, optionally round, pack low halves
// - Q31 tops to Q15, optional round clamp
// - Q15 values clamped to unsigned bytes
`timescale 1ns/1ns
`default_nettype none
`include "simd_arith_params.svh"

module simd_fraction_arith_unit (
	// Clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RST_N,
	// Issue from the pipeline
	input  wire logic                    OP_VALID,
	input  wire simd_arith_pkg::op_sel_type OP_SEL,
	input  wire simd_arith_pkg::word_type  SRC_ONE,
	input  wire simd_arith_pkg::word_type  SRC_TWO,
	input  wire simd_arith_pkg::dest_type  DEST_IDX,
	input  wire simd_arith_pkg::shift_type SHIFT_AMT,
	// Result to the general registers
	output logic                         RES_VALID,
	output simd_arith_pkg::dest_type     RES_DEST,
	output simd_arith_pkg::word_type     RES_DATA,
	// Carry bit of the control register
	output logic                         CARRY_FLAG
);
	import simd_arith_pkg::*;

	// Clamp a 17-bit signed sum to Q15
	function automatic logic [15:0] sat16(input logic [16:0] v);
		if (v[16] != v[15])
			return v[16] ? `Q15_MIN : `Q15_MAX;
		return v[15:0];
	endfunction

	// Clamp a 33-bit signed sum to Q31
	function automatic logic [31:0] sat32(input logic [32:0] v);
		if (v[32] != v[31])
			return v[32] ? `Q31_MIN : `Q31_MAX;
		return v[31:0];
	endfunction

	// Magnitude of a Q15 half
	function automatic logic [15:0] abs16(input logic [15:0] h);
		if (h == `Q15_MIN)
			return `Q15_MAX;
		return h[15] ? 16'(-h) : h;
	endfunction

	// Magnitude of a Q31 word
	function automatic logic [31:0] abs32(input logic [31:0] w);
		if (w == `Q31_MIN)
			return `Q31_MAX;
		return w[31] ? 32'(-w) : w;
	endfunction

	// Result and control state
	logic     valid_reg;   // Result present
	dest_type dest_reg;    // Destination index
	word_type data_reg;    // Result word
	word_type data_next;   // Result word being formed
	logic     carry_reg;   // Held carry bit
	logic     carry_next;  // Carry bit after this operation

	// Per-lane results
	word_type half_add;    // Q15 pair add, wrapping
	word_type half_add_s;  // Q15 pair add, clamped
	word_type half_sub;    // Q15 pair subtract, wrapping
	word_type half_sub_s;  // Q15 pair subtract, clamped
	word_type half_abs;    // Q15 pair magnitude
	word_type byte_add;    // Byte add, wrapping
	word_type byte_add_s;  // Byte add, clamped
	word_type byte_sub;    // Byte sub, wrapping
	word_type byte_sub_s;  // Byte sub, floored

	// Whole-word results
	logic [32:0] word_sum;    // Sign-extended Q31 sum
	logic [32:0] word_diff;   // Sign-extended Q31 difference
	logic [32:0] carry_sum;   // Unsigned sum with carry out
	logic [32:0] carry_in_sum; // Unsigned sum plus held carry
	logic [9:0]  byte_total;  // Reduction of four bytes
	logic [32:0] index_diff;  // Index minus decrement
	word_type    index_out;   // Circular index result

	// Packing unit link
	pack_if pk ();

	// Two Q15 lanes
	for (genvar g = 0; g < 2; g++) begin : g_half
		logic [16:0] s;  // Lane sum
		logic [16:0] d;  // Lane difference
		assign s = {SRC_ONE[16*g+15], SRC_ONE[16*g +: 16]}
			+ {SRC_TWO[16*g+15], SRC_TWO[16*g +: 16]};
		assign d = {SRC_ONE[16*g+15], SRC_ONE[16*g +: 16]}
			- {SRC_TWO[16*g+15], SRC_TWO[16*g +: 16]};
		assign half_add[16*g +: 16]   = s[15:0];
		assign half_add_s[16*g +: 16] = sat16(s);
		assign half_sub[16*g +: 16]   = d[15:0];
		assign half_sub_s[16*g +: 16] = sat16(d);
		assign half_abs[16*g +: 16]   = abs16(SRC_TWO[16*g +: 16]);
	end

	// Four unsigned byte lanes
	for (genvar g = 0; g < 4; g++) begin : g_byte
		logic [8:0] s;  // Lane sum with carry
		logic [8:0] d;  // Lane difference with borrow
		assign s = {1'b0, SRC_ONE[8*g +: 8]} + {1'b0, SRC_TWO[8*g +: 8]};
		assign d = {1'b0, SRC_ONE[8*g +: 8]} - {1'b0, SRC_TWO[8*g +: 8]};
		assign byte_add[8*g +: 8]   = s[7:0];
		assign byte_add_s[8*g +: 8] = s[8] ? `UBYTE_MAX : s[7:0];
		assign byte_sub[8*g +: 8]   = d[7:0];
		assign byte_sub_s[8*g +: 8] = d[8] ? `UBYTE_MIN : d[7:0];
	end

	// Word arithmetic
	assign word_sum     = {SRC_ONE[31], SRC_ONE} + {SRC_TWO[31], SRC_TWO};
	assign word_diff    = {SRC_ONE[31], SRC_ONE} - {SRC_TWO[31], SRC_TWO};
	assign carry_sum    = {1'b0, SRC_ONE} + {1'b0, SRC_TWO};
	assign carry_in_sum = carry_sum + {32'h0000_0000, carry_reg};
	assign byte_total   = {2'b00, SRC_ONE[31:24]} + {2'b00, SRC_ONE[23:16]}
		+ {2'b00, SRC_ONE[15:8]} + {2'b00, SRC_ONE[7:0]};

	// Circular index: borrow means the index went below zero
	assign index_diff = {1'b0, SRC_ONE}
		- {25'h000_0000, SRC_TWO[`DECR_LSB +: `BYTE_W]};
	assign index_out  = index_diff[32]
		? {16'h0000, SRC_TWO[`RELOAD_LSB +: `RELOAD_W]} : index_diff[31:0];

	// Drive the packing unit
	assign pk.sel       = OP_SEL;
	assign pk.src_one   = SRC_ONE;
	assign pk.src_two   = SRC_TWO;
	assign pk.shift_amt = SHIFT_AMT;

	pack_unit u_pack (
		.pk (pk.packer)
	);

	// Pick the result of the selected operation
	always_comb begin
		data_next = `WORD_RST;
		if (OP_SEL[q15_pair_add])
			data_next = half_add;
		if (OP_SEL[q15_pair_add_sat])
			data_next = half_add_s;
		if (OP_SEL[q31_add_sat])
			data_next = sat32(word_sum);
		if (OP_SEL[byte_quad_add])
			data_next = byte_add;
		if (OP_SEL[byte_quad_add_sat])
			data_next = byte_add_s;
		if (OP_SEL[q15_pair_sub])
			data_next = half_sub;
		if (OP_SEL[q15_pair_sub_sat])
			data_next = half_sub_s;
		if (OP_SEL[q31_sub_sat])
			data_next = sat32(word_diff);
		if (OP_SEL[byte_quad_sub])
			data_next = byte_sub;
		if (OP_SEL[byte_quad_sub_sat])
			data_next = byte_sub_s;
		if (OP_SEL[add_set_carry])
			data_next = carry_sum[31:0];
		if (OP_SEL[add_with_carry])
			data_next = carry_in_sum[31:0];
		if (OP_SEL[circular_index_decrement])
			data_next = index_out;
		if (OP_SEL[byte_sum_reduce])
			data_next = {22'h00_0000, byte_total};
		if (OP_SEL[q15_pair_magnitude])
			data_next = half_abs;
		if (OP_SEL[q31_magnitude])
			data_next = abs32(SRC_TWO);
		if (OP_SEL[pack_q15_to_q7] | OP_SEL[shift_pack_words]
			| OP_SEL[shift_round_pack_words] | OP_SEL[pack_q31_to_q15]
			| OP_SEL[pack_q31_to_q15_round_sat] | OP_SEL[pack_q15_to_ubyte_sat])
			data_next = pk.result;
	end

	// Only the set-carry add changes the held carry
	always_comb begin
		carry_next = carry_reg;
		if (OP_VALID && OP_SEL[add_set_carry])
			carry_next = carry_sum[32];
	end

	// Result registers, one cycle after issue
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			valid_reg <= 1'b0;
			dest_reg  <= '0;
			data_reg  <= `WORD_RST;
		end else begin
			valid_reg <= OP_VALID;
			if (OP_VALID) begin
				dest_reg <= DEST_IDX;
				data_reg <= data_next;
			end
		end
	end

	// Carry bit of the control register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			carry_reg <= `CARRY_RST;
		else
			carry_reg <= carry_next;
	end

	// Outputs
	assign RES_VALID  = valid_reg;
	assign RES_DEST   = dest_reg;
	assign RES_DATA   = data_reg;
	assign CARRY_FLAG = carry_reg;

	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_result_one_cycle: assert property (
		OP_VALID |=> RES_VALID && RES_DEST == $past(DEST_IDX))
		else $error("Result not returned one cycle after issue");

	a_q31_add_clamp: assert property (
		OP_VALID && OP_SEL[q31_add_sat] && !SRC_ONE[31] && !SRC_TWO[31]
		&& word_sum[31] |=> RES_DATA == 32'h7FFF_FFFF)
		else $error("Q31 add overflow not clamped");

	a_q31_sub_clamp: assert property (
		OP_VALID && OP_SEL[q31_sub_sat] && SRC_ONE == 32'h8000_0000
		&& SRC_TWO == 32'h0000_0001 |=> RES_DATA == 32'h8000_0000)
		else $error("Q31 subtract underflow not clamped");

	a_byte_add_clamp: assert property (
		OP_VALID && OP_SEL[byte_quad_add_sat] && SRC_ONE == 32'hFFFF_FFFF
		|=> RES_DATA == 32'hFFFF_FFFF)
		else $error("Byte add not clamped to 255");

	a_byte_sub_floor: assert property (
		OP_VALID && OP_SEL[byte_quad_sub_sat] && SRC_ONE == 32'h0000_0000
		|=> RES_DATA == 32'h0000_0000)
		else $error("Byte subtract not floored at zero");

	a_q15_abs_min: assert property (
		OP_VALID && OP_SEL[q15_pair_magnitude] && SRC_TWO == 32'h8000_8000
		|=> RES_DATA == 32'h7FFF_7FFF)
		else $error("Q15 magnitude of -1.0 not clamped");

	a_q31_abs_min: assert property (
		OP_VALID && OP_SEL[q31_magnitude] && SRC_TWO == 32'h8000_0000
		|=> RES_DATA == 32'h7FFF_FFFF)
		else $error("Q31 magnitude of -1.0 not clamped");

	a_carry_capture: assert property (
		OP_VALID && OP_SEL[add_set_carry] |=> CARRY_FLAG == $past(carry_sum[32]))
		else $error("Carry out not recorded");

	a_carry_hold: assert property (
		!(OP_VALID && OP_SEL[add_set_carry]) |=> CARRY_FLAG == $past(CARRY_FLAG))
		else $error("Carry changed by another operation");

	a_reduce_width: assert property (
		OP_VALID && OP_SEL[byte_sum_reduce] && SRC_ONE == 32'h8080_8080
		|=> RES_DATA == 32'h0000_0200)
		else $error("Byte reduction wrong");

	a_q15_add_wrap: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[q15_pair_add]
		|=> RES_DATA == {$past(SRC_ONE[31:16]) + $past(SRC_TWO[31:16]),
			$past(SRC_ONE[15:0]) + $past(SRC_TWO[15:0])})
		else $error("Q15 pair add lanes wrong");

	a_q15_add_clamp: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[q15_pair_add_sat]
		&& SRC_ONE[31:16] == `Q15_MAX && !SRC_TWO[31] |=> RES_DATA[31:16] == `Q15_MAX)
		else $error("Q15 pair add overflow not clamped");

	a_q15_sub_wrap: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[q15_pair_sub]
		|=> RES_DATA == {$past(SRC_ONE[31:16]) - $past(SRC_TWO[31:16]),
			$past(SRC_ONE[15:0]) - $past(SRC_TWO[15:0])})
		else $error("Q15 pair subtract lanes wrong");

	a_q15_sub_clamp: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[q15_pair_sub_sat]
		&& SRC_ONE[31:16] == `Q15_MIN && !SRC_TWO[31] |=> RES_DATA[31:16] == `Q15_MIN)
		else $error("Q15 pair subtract underflow not clamped");

	a_carry_sum: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[add_set_carry]
		|=> RES_DATA == $past(SRC_ONE) + $past(SRC_TWO))
		else $error("Set-carry add sum wrong");

	a_carry_in_sum: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[add_with_carry]
		|=> RES_DATA == $past(SRC_ONE) + $past(SRC_TWO) + 32'($past(CARRY_FLAG)))
		else $error("Add with held carry wrong");

	a_index_step: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[circular_index_decrement]
		&& SRC_ONE >= 32'(SRC_TWO[`DECR_LSB +: `BYTE_W])
		|=> RES_DATA == $past(SRC_ONE) - 32'($past(SRC_TWO[`DECR_LSB +: `BYTE_W])))
		else $error("Index step wrong");

	a_index_reload: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[circular_index_decrement]
		&& SRC_ONE < 32'(SRC_TWO[`DECR_LSB +: `BYTE_W])
		|=> RES_DATA == 32'($past(SRC_TWO[`RELOAD_LSB +: `RELOAD_W])))
		else $error("Index reload not written");

	a_pack_q7_order: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[pack_q15_to_q7]
		|=> RES_DATA == {$past(SRC_ONE[31:24]), $past(SRC_ONE[15:8]),
			$past(SRC_TWO[31:24]), $past(SRC_TWO[15:8])})
		else $error("Q7 pack order wrong");

	a_shift_pack: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[shift_pack_words]
		|=> RES_DATA == {16'($signed($past(SRC_TWO)) >>> $past(SHIFT_AMT)),
			16'($signed($past(SRC_ONE)) >>> $past(SHIFT_AMT))})
		else $error("Shift pack wrong");

	a_pack_q15_order: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[pack_q31_to_q15]
		|=> RES_DATA == {$past(SRC_ONE[31:16]), $past(SRC_TWO[31:16])})
		else $error("Q15 pack order wrong");

	a_pack_round_top: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[pack_q31_to_q15_round_sat]
		&& !SRC_ONE[31] && SRC_ONE > `Q31_RND_TOP |=> RES_DATA[31:16] == `Q15_MAX)
		else $error("Rounded pack not clamped");

	a_ubyte_floor: assert property (
		OP_VALID && $onehot(OP_SEL) && OP_SEL[pack_q15_to_ubyte_sat] && SRC_ONE[31]
		|=> RES_DATA[31:24] == `UBYTE_MIN)
		else $error("Negative Q15 not floored at zero");

	c_add_carry_chain: cover property (
		OP_VALID && OP_SEL[add_set_carry] && carry_sum[32]
		##1 OP_VALID && OP_SEL[add_with_carry]);
	c_index_reload: cover property (
		OP_VALID && OP_SEL[circular_index_decrement] && index_diff[32]);
	c_round_pack: cover property (
		OP_VALID && OP_SEL[shift_round_pack_words] && SHIFT_AMT != 5'd0);

endmodule

`default_nettype wire

// [verilog/simd_arith_params.svh]
`ifndef SIMD_ARITH_PARAMS_SVH
`define SIMD_ARITH_PARAMS_SVH

// Operand and field widths
`define WORD_W       32
`define HALF_W       16
`define BYTE_W       8
`define DEST_W       5
`define SHIFT_W      5
`define OP_COUNT     22

// Saturation limits
`define Q15_MAX      16'h7FFF
`define Q15_MIN      16'h8000
`define Q31_MAX      32'h7FFF_FFFF
`define Q31_MIN      32'h8000_0000
`define UBYTE_MAX    8'hFF
`define UBYTE_MIN    8'h00

// Circular index operand layout in the second source
`define DECR_LSB     0
`define RELOAD_LSB   8
`define RELOAD_W     16

// Q31 to Q15 rounding constants
`define Q31_RND_ADD  32'h0000_8000
`define Q31_RND_TOP  32'h7FFF_7FFF

// Q15 to unsigned byte clamp threshold
`define UB_CLAMP_TOP 16'h7F80

// Reset values
`define CARRY_RST    1'b0
`define WORD_RST     32'h0000_0000

`endif

// [verilog/simd_arith_pkg.sv]
`default_nettype none
`include "simd_arith_params.svh"

package simd_arith_pkg;

	// Operation index, one bit of the one-hot select per entry
	typedef enum {
		q15_pair_add, q15_pair_add_sat, q31_add_sat,
		byte_quad_add, byte_quad_add_sat,
		q15_pair_sub, q15_pair_sub_sat, q31_sub_sat,
		byte_quad_sub, byte_quad_sub_sat,
		add_set_carry, add_with_carry,
		circular_index_decrement, byte_sum_reduce,
		q15_pair_magnitude, q31_magnitude,
		pack_q15_to_q7, shift_pack_words, shift_round_pack_words,
		pack_q31_to_q15, pack_q31_to_q15_round_sat, pack_q15_to_ubyte_sat
	} op_index_type;

	// Data carriers
	typedef logic [`OP_COUNT-1:0] op_sel_type;
	typedef logic [`WORD_W-1:0]   word_type;
	typedef logic [`DEST_W-1:0]   dest_type;
	typedef logic [`SHIFT_W-1:0]  shift_type;

endpackage

`default_nettype wire

// [verilog/pack_if.sv]
`timescale 1ns/1ns
`default_nettype none

// Operands to the packing unit and its result back
interface pack_if;
	import simd_arith_pkg::*;
	op_sel_type sel;        // One-hot operation select
	word_type   src_one;    // First source word
	word_type   src_two;    // Second source word
	shift_type  shift_amt;  // Shift amount
	word_type   result;     // Packed result, combinational

	modport issue  (output sel, src_one, src_two, shift_amt, input result);
	modport packer (input sel, src_one, src_two, shift_amt, output result);
endinterface

`default_nettype wire

// [verilog/pack_unit.sv]
`timescale 1ns/1ns
`default_nettype none
`include "simd_arith_params.svh"

// Precision-reducing packing, purely combinational
module pack_unit (
	pack_if.packer pk
);
	import simd_arith_pkg::*;

	// Shift word right arithmetically, optional round at top discard bit
	function automatic logic [15:0] shr_half(input logic [31:0] w, input logic [4:0] s,
		input logic rnd);
		logic signed [32:0] e;
		logic [4:0]         sm1;
		e = $signed({w[31], w});
		sm1 = s - 5'd1;
		if (rnd && s != 5'd0) begin
			e = e >>> sm1;
			e = e + 33'sd1;
			e = e >>> 1;
		end else begin
			e = e >>> s;
		end
		return e[15:0];
	endfunction

	// Round a Q31 word to Q15 with clamp at the top
	function automatic logic [15:0] q31_round(input logic [31:0] w);
		logic [31:0] r;
		r = w + `Q31_RND_ADD;
		if (!w[31] && w > `Q31_RND_TOP)
			return `Q15_MAX;
		return r[31:16];
	endfunction

	// Clamp a Q15 value to an unsigned byte
	function automatic logic [7:0] q15_ubyte(input logic [15:0] h);
		if (h[15])
			return `UBYTE_MIN;
		if (h > `UB_CLAMP_TOP)
			return `UBYTE_MAX;
		return h[14:7];
	endfunction

	// Select the packing result
	always_comb begin
		pk.result = `WORD_RST;
		if (pk.sel[pack_q15_to_q7])
			pk.result = {pk.src_one[31:24], pk.src_one[15:8],
				pk.src_two[31:24], pk.src_two[15:8]};
		if (pk.sel[shift_pack_words])
			pk.result = {shr_half(pk.src_two, pk.shift_amt, 1'b0),
				shr_half(pk.src_one, pk.shift_amt, 1'b0)};
		if (pk.sel[shift_round_pack_words])
			pk.result = {shr_half(pk.src_two, pk.shift_amt, 1'b1),
				shr_half(pk.src_one, pk.shift_amt, 1'b1)};
		if (pk.sel[pack_q31_to_q15])
			pk.result = {pk.src_one[31:16], pk.src_two[31:16]};
		if (pk.sel[pack_q31_to_q15_round_sat])
			pk.result = {q31_round(pk.src_one), q31_round(pk.src_two)};
		if (pk.sel[pack_q15_to_ubyte_sat])
			pk.result = {q15_ubyte(pk.src_one[31:16]), q15_ubyte(pk.src_one[15:0]),
				q15_ubyte(pk.src_two[31:16]), q15_ubyte(pk.src_two[15:0])};
	end

endmodule

`default_nettype wire

// [sim/pipe_issuer.sv]
`timescale 1ns/1ns
`default_nettype none

// Pipeline side: presents one decoded operation per call
module pipe_issuer (
	// Clock
	input  wire logic                       CLK,
	// Issue to the unit
	output logic                            OP_VALID,
	output simd_arith_pkg::op_sel_type      OP_SEL,
	output simd_arith_pkg::word_type        SRC_ONE,
	output simd_arith_pkg::word_type        SRC_TWO,
	output simd_arith_pkg::dest_type        DEST_IDX,
	output simd_arith_pkg::shift_type       SHIFT_AMT
);
	import simd_arith_pkg::*;

	// Idle levels from time zero
	initial begin
		OP_VALID = 1'b0;
		OP_SEL = '0;
		SRC_ONE = '0;
		SRC_TWO = '0;
		DEST_IDX = '0;
		SHIFT_AMT = '0;
	end

	// All operands together, changed off the sampling edge
	task automatic drive(op_sel_type s, word_type a, word_type b, dest_type d, shift_type h);
		@(negedge CLK);
		OP_VALID = 1'b1;
		OP_SEL = s;
		SRC_ONE = a;
		SRC_TWO = b;
		DEST_IDX = d;
		SHIFT_AMT = h;
	endtask

	// Strobe down; stale select, sources and shift flipped so nothing leans on them; DEST_IDX kept
	task automatic idle();
		OP_VALID = 1'b0;
		OP_SEL = ~OP_SEL;
		SRC_ONE = ~SRC_ONE;
		SRC_TWO = ~SRC_TWO;
		SHIFT_AMT = ~SHIFT_AMT;
	endtask
endmodule

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import simd_arith_pkg::*;
	logic       clk;          // Core clock
	logic       rst_n;        // Reset, active low
	wire logic  op_valid;     // Issue strobe
	wire op_sel_type sel;     // One-hot select
	wire word_type   src_one; // First source
	wire word_type   src_two; // Second source
	wire dest_type   dest_idx;// Destination index
	wire shift_type  shamt;   // Shift amount
	wire logic  res_valid;    // Result strobe
	wire dest_type   res_dest;// Result destination
	wire word_type   res_data;// Result word
	wire logic  carry_flag;   // Held carry bit
	int         fails;        // Mismatches
	int         total_checks; // Comparisons
	int         dest;         // Destination counter

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Far side
	pipe_issuer u_p (.CLK(clk), .OP_VALID(op_valid), .OP_SEL(sel), .SRC_ONE(src_one),
		.SRC_TWO(src_two), .DEST_IDX(dest_idx), .SHIFT_AMT(shamt));

	simd_fraction_arith_unit DUT (.CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid),
		.OP_SEL(sel), .SRC_ONE(src_one), .SRC_TWO(src_two), .DEST_IDX(dest_idx),
		.SHIFT_AMT(shamt), .RES_VALID(res_valid), .RES_DEST(res_dest),
		.RES_DATA(res_data), .CARRY_FLAG(carry_flag));

	// Compare and count
	task automatic chk(string name, word_type exp, word_type got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Select bit of one operation
	function automatic op_sel_type sel_of(op_index_type o);
		return op_sel_type'(1) << o;
	endfunction

	// One issue; answer one cycle later, strobe for one cycle
	task automatic run(op_sel_type s, word_type a, word_type b, shift_type h, word_type exp);
		dest_type d;
		d = dest_type'(dest);
		dest++;
		u_p.drive(s, a, b, d, h);
		@(negedge clk);
		chk("RES_VALID", 32'h0000_0001, word_type'(res_valid));
		chk("RES_DEST", word_type'(d), word_type'(res_dest));
		chk("RES_DATA", exp, res_data);
		u_p.idle();
		@(negedge clk);
		chk("RES_VALID low", 32'h0000_0000, word_type'(res_valid));
		chk("RES_DATA held", exp, res_data);
	endtask

	// Outputs cleared while reset is low
	task automatic t_reset();
		chk("RES_VALID", 32'h0000_0000, word_type'(res_valid));
		chk("RES_DATA", 32'h0000_0000, res_data);
		chk("CARRY_FLAG", 32'h0000_0000, word_type'(carry_flag));
	endtask

	// Halfword lanes, wrap and clamp
	task automatic t_q15();
		run(sel_of(q15_pair_add), 32'h7FFF_8000, 32'h0001_FFFF, 0, 32'h8000_7FFF);
		run(sel_of(q15_pair_add_sat), 32'h7FFF_8000, 32'h0001_FFFF, 0, 32'h7FFF_8000);
		run(sel_of(q15_pair_sub), 32'h8000_0005, 32'h0001_0007, 0, 32'h7FFF_FFFE);
		run(sel_of(q15_pair_sub_sat), 32'h8000_7FFF, 32'h0001_FFFF, 0, 32'h8000_7FFF);
		$display("test q15 done");
	endtask

	// Word clamps in both directions
	task automatic t_q31();
		run(sel_of(q31_add_sat), 32'h7FFF_FFFF, 32'h0000_0001, 0, 32'h7FFF_FFFF);
		run(sel_of(q31_add_sat), 32'h8000_0000, 32'hFFFF_FFFF, 0, 32'h8000_0000);
		run(sel_of(q31_add_sat), 32'h1234_0000, 32'h0000_5678, 0, 32'h1234_5678);
		run(sel_of(q31_sub_sat), 32'h8000_0000, 32'h0000_0001, 0, 32'h8000_0000);
		run(sel_of(q31_sub_sat), 32'h7FFF_FFFF, 32'hFFFF_FFFF, 0, 32'h7FFF_FFFF);
		$display("test q31 done");
	endtask

	// Unsigned byte lanes
	task automatic t_bytes();
		run(sel_of(byte_quad_add), 32'h80FF_0102, 32'h8002_0304, 0, 32'h0001_0406);
		run(sel_of(byte_quad_add_sat), 32'h80FF_0102, 32'h8002_0304, 0, 32'hFFFF_0406);
		run(sel_of(byte_quad_sub), 32'h0510_FF00, 32'h0620_0101, 0, 32'hFFF0_FEFF);
		run(sel_of(byte_quad_sub_sat), 32'h0510_FF00, 32'h0620_0101, 0, 32'h0000_FE00);
		run(sel_of(byte_quad_add_sat), 32'hFFFF_FFFF, 32'h0102_0304, 0, 32'hFFFF_FFFF);
		run(sel_of(byte_quad_sub_sat), 32'h0000_0000, 32'h0102_0304, 0, 32'h0000_0000);
		$display("test bytes done");
	endtask

	// Carry recorded, consumed, kept, then cleared by reset
	task automatic t_carry();
		run(sel_of(add_set_carry), 32'hFFFF_FFFF, 32'h0000_0001, 0, 32'h0000_0000);
		chk("CARRY_FLAG", 32'h0000_0001, word_type'(carry_flag));
		run(sel_of(add_with_carry), 32'h0000_0001, 32'h0000_0002, 0, 32'h0000_0004);
		chk("CARRY_FLAG", 32'h0000_0001, word_type'(carry_flag));
		run(sel_of(add_set_carry), 32'h0000_0001, 32'h0000_0001, 0, 32'h0000_0002);
		chk("CARRY_FLAG", 32'h0000_0000, word_type'(carry_flag));
		run(sel_of(add_with_carry), 32'h0000_0001, 32'h0000_0002, 0, 32'h0000_0003);
		run(sel_of(add_set_carry), 32'h8000_0000, 32'h8000_0000, 0, 32'h0000_0000);
		rst_n = 1'b0;
		@(negedge clk);
		t_reset();
		rst_n = 1'b1;
		$display("test carry done");
	endtask

	// Index step, boundary and reload
	task automatic t_index();
		run(sel_of(circular_index_decrement), 32'h0000_0010, 32'h0000_4004, 0, 32'h0000_000C);
		run(sel_of(circular_index_decrement), 32'h0000_0004, 32'h0000_4004, 0, 32'h0000_0000);
		run(sel_of(circular_index_decrement), 32'h0000_0002, 32'h0000_4004, 0, 32'h0000_0040);
		$display("test index done");
	endtask

	// Byte sum and magnitudes
	task automatic t_reduce();
		run(sel_of(byte_sum_reduce), 32'h8080_8080, 32'h0000_0000, 0, 32'h0000_0200);
		run(sel_of(byte_sum_reduce), 32'hFFFF_FFFF, 32'h0000_0000, 0, 32'h0000_03FC);
		run(sel_of(q15_pair_magnitude), 32'h0000_0000, 32'h8000_FFFB, 0, 32'h7FFF_0005);
		run(sel_of(q15_pair_magnitude), 32'h0000_0000, 32'h8000_8000, 0, 32'h7FFF_7FFF);
		run(sel_of(q31_magnitude), 32'h0000_0000, 32'h8000_0000, 0, 32'h7FFF_FFFF);
		run(sel_of(q31_magnitude), 32'h0000_0000, 32'hFFFF_FFFE, 0, 32'h0000_0002);
		$display("test reduce done");
	endtask

	// Precision reducing packs
	task automatic t_pack();
		run(sel_of(pack_q15_to_q7), 32'h1234_5678, 32'h9ABC_DEF0, 0, 32'h1256_9ADE);
		run(sel_of(shift_pack_words), 32'h0001_2348, 32'hFFF0_0008, 4, 32'h0000_1234);
		run(sel_of(shift_round_pack_words), 32'h0001_2348, 32'hFFF0_0008, 4, 32'h0001_1235);
		run(sel_of(shift_round_pack_words), 32'h0001_2348, 32'hFFF0_0008, 0, 32'h0008_2348);
		run(sel_of(pack_q31_to_q15), 32'h1234_5678, 32'hABCD_EF01, 0, 32'h1234_ABCD);
		run(sel_of(pack_q31_to_q15_round_sat), 32'h7FFF_8000, 32'h1234_8000, 0, 32'h7FFF_1235);
		run(sel_of(pack_q15_to_ubyte_sat), 32'h8000_7FFF, 32'h4000_0080, 0, 32'h00FF_8001);
		run(op_sel_type'(0), 32'h1234_5678, 32'h1111_1111, 0, 32'h0000_0000);
		$display("test pack done");
	endtask

	// Back to back issue; second add sees the carry just set
	task automatic t_chain();
		u_p.drive(sel_of(add_set_carry), 32'hFFFF_FFFF, 32'h0000_0002, 5'd7, 5'd0);
		u_p.drive(sel_of(add_with_carry), 32'h0000_0010, 32'h0000_0020, 5'd8, 5'd0);
		chk("RES_VALID", 32'h0000_0001, word_type'(res_valid));
		chk("RES_DEST", 32'h0000_0007, word_type'(res_dest));
		chk("RES_DATA", 32'h0000_0001, res_data);
		chk("CARRY_FLAG", 32'h0000_0001, word_type'(carry_flag));
		@(negedge clk);
		u_p.idle();
		chk("RES_VALID", 32'h0000_0001, word_type'(res_valid));
		chk("RES_DEST", 32'h0000_0008, word_type'(res_dest));
		chk("RES_DATA", 32'h0000_0031, res_data);
		@(negedge clk);
		chk("RES_VALID low", 32'h0000_0000, word_type'(res_valid));
		$display("test chain done");
	endtask

	// Counts, verdict, stop
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		fails = 0;
		total_checks = 0;
		dest = 1;
		repeat (10) @(negedge clk);
		t_reset();
		rst_n = 1'b1;
		t_q15();
		t_q31();
		t_bytes();
		t_carry();
		t_chain();
		t_index();
		t_reduce();
		t_pack();
		end_of_test();
	end

	// Hang guard
	initial begin
		#(40 * 5000);
		fails++;
		end_of_test();
	end
endmodule

`default_nettype wire
